// ===== hdl/dmairq_regs.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module dmairq_regs
    import dmairq_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire dmairq_pkg::dmairq_evt_t evt,
    input  wire logic [15:0]         hw_burst_req,
    input  wire logic [15:0]         hw_single_req,
    output logic      [15:0]         burst_req_out,
    output logic      [15:0]         single_req_out,
    output logic      [7:0]          chan_enable_out,
    output dmairq_pkg::dmairq_irq_t  irq
);
    import dmairq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0]  tc_mask;     // terminal count interrupt mask
        logic [7:0]  err_mask;    // error interrupt mask
        logic [31:0] rdata;       // read data register
        logic        slverr;      // unmapped access, or write to a read-only register, answer
        logic [15:0] burst_req;   // registered request to engines
        logic [15:0] single_req;  // registered request to engines
        logic [7:0]  chan_en;     // registered enables to engines
        dmairq_irq_t irq;         // registered interrupt outputs
        logic        rdy;         // access acknowledged, drives pready
    } dmairq_state_t;

    dmairq_state_t st_reg;        // current state
    dmairq_state_t st_next;       // next state

    logic [7:0]  raw_tc_bits;     // raw terminal count flags
    logic [7:0]  raw_err_bits;    // raw error flags
    logic [7:0]  channel_active_bits; // enabled channel flags
    logic [15:0] sw_burst_bits;   // software burst requests
    logic [15:0] sw_single_bits;  // software single requests
    logic [7:0]  tc_clear_bits;   // clear strobes
    logic [7:0]  err_clear_bits;  // clear strobes
    logic [7:0]  chan_set;        // channel enable strobes
    logic [7:0]  chan_clr;        // channel disable or done
    logic [15:0] burst_set;       // software burst set strobes
    logic [15:0] single_set;      // software single set strobes
    logic [7:0]  masked_tc_bits;  // after masking
    logic [7:0]  masked_err_bits; // after masking
    logic [7:0]  masked_irq_bits; // combined per channel
    logic        wr_acc;          // write access phase
    logic        rd_acc;          // read access phase
    logic        wr_take;         // edge at which a write lands

    ////////////////////////////////////////////////////////////////////////////
    // decode helper
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    // a write lands once, at the edge where pready is sampled high
    assign wr_take = wr_acc & st_reg.rdy;

    // write strobes, live on the pready edge only so a clear never hits twice
    always_comb begin
        tc_clear_bits  = (wr_take && hit(paddr, OFS_TC_CLEAR))
                         ? pwdata[7:0] : RST_CHAN;
        err_clear_bits = (wr_take && hit(paddr, OFS_ERR_CLEAR))
                         ? pwdata[7:0] : RST_CHAN;
        // ones set, zeros do nothing
        burst_set  = (wr_take && hit(paddr, OFS_SW_BURST))
                     ? pwdata[15:0] : RST_SRC;
        single_set = (wr_take && hit(paddr, OFS_SW_SINGLE))
                     ? pwdata[15:0] : RST_SRC;
        chan_set   = (wr_take && hit(paddr, OFS_CHAN_ENABLE)) ? pwdata[7:0] : RST_CHAN;
        // a channel clears itself on completion; enable write of zero disables
        chan_clr   = evt.chan_done |
                     ((wr_take && hit(paddr, OFS_CHAN_ENABLE)) ? ~pwdata[7:0] : RST_CHAN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flag banks
    dmairq_sticky #(.W(NUM_CHAN)) u_tc (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (evt.tc_set),
        .clr_bits (tc_clear_bits),
        .flags    (raw_tc_bits)
    );

    dmairq_sticky #(.W(NUM_CHAN)) u_err (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (evt.err_set),
        .clr_bits (err_clear_bits),
        .flags    (raw_err_bits)
    );

    dmairq_sticky #(.W(NUM_CHAN)) u_chan (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (chan_set & ~evt.chan_done),
        .clr_bits (chan_clr),
        .flags    (channel_active_bits)
    );

    // software request bits stay until the transaction completes
    dmairq_sticky #(.W(NUM_SRC)) u_sb (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (burst_set),
        .clr_bits (evt.burst_done),
        .flags    (sw_burst_bits)
    );

    dmairq_sticky #(.W(NUM_SRC)) u_ss (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (single_set),
        .clr_bits (evt.single_done),
        .flags    (sw_single_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // masking
    always_comb begin
        masked_tc_bits  = raw_tc_bits & st_reg.tc_mask;
        masked_err_bits = raw_err_bits & st_reg.err_mask;
        masked_irq_bits = masked_tc_bits | masked_err_bits;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next        = st_reg;
        st_next.slverr = 1'b0;
        // mask registers
        if (wr_take && hit(paddr, OFS_TC_MASK)) begin
            st_next.tc_mask = pwdata[7:0];
        end
        if (wr_take && hit(paddr, OFS_ERR_MASK)) begin
            st_next.err_mask = pwdata[7:0];
        end
        // read mux; unused upper bits read zero
        if (rd_acc) begin
            case (paddr)
                OFS_MASKED_IRQ:  st_next.rdata = {24'h000000, masked_irq_bits};
                OFS_MASKED_TC:   st_next.rdata = {24'h000000, masked_tc_bits};
                OFS_MASKED_ERR:  st_next.rdata = {24'h000000, masked_err_bits};
                OFS_RAW_TC:      st_next.rdata = {24'h000000, raw_tc_bits};
                OFS_RAW_ERR:     st_next.rdata = {24'h000000, raw_err_bits};
                OFS_CHAN_ACTIVE: st_next.rdata = {24'h000000, channel_active_bits};
                // sources currently requesting, either origin
                OFS_SW_BURST:    st_next.rdata = {16'h0000,
                                                  sw_burst_bits | hw_burst_req};
                OFS_SW_SINGLE:   st_next.rdata = {16'h0000,
                                                  sw_single_bits | hw_single_req};
                OFS_TC_MASK:     st_next.rdata = {24'h000000, st_reg.tc_mask};
                OFS_ERR_MASK:    st_next.rdata = {24'h000000, st_reg.err_mask};
                OFS_CHAN_ENABLE: st_next.rdata = {24'h000000, channel_active_bits};
                OFS_TC_CLEAR,
                OFS_ERR_CLEAR:   st_next.rdata = RST_WORD;   // write-only reads zero
                default: begin
                    st_next.rdata  = RST_WORD;
                    st_next.slverr = 1'b1;                   // unmapped address
                end
            endcase
        end else if (wr_acc) begin
            case (paddr)
                OFS_TC_CLEAR, OFS_ERR_CLEAR, OFS_SW_BURST, OFS_SW_SINGLE,
                OFS_TC_MASK, OFS_ERR_MASK, OFS_CHAN_ENABLE: st_next.slverr = 1'b0;
                default: st_next.slverr = 1'b1;              // unmapped or read-only
            endcase
        end
        // either origin of a request reaches the engines
        st_next.burst_req  = sw_burst_bits | hw_burst_req;
        st_next.single_req = sw_single_bits | hw_single_req;
        st_next.chan_en    = channel_active_bits;
        // interrupt outputs
        st_next.irq.combined = |masked_irq_bits;
        st_next.irq.tc       = |masked_tc_bits;
        st_next.irq.err      = |masked_err_bits;
        // one wait state: answer in the second access cycle, for one cycle
        st_next.rdy          = psel & penable & ~st_reg.rdy;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign prdata          = st_reg.rdata;
    assign pslverr         = st_reg.slverr;
    assign burst_req_out   = st_reg.burst_req;
    assign single_req_out  = st_reg.single_req;
    assign chan_enable_out = st_reg.chan_en;
    assign irq             = st_reg.irq;

    assign pready          = st_reg.rdy;
endmodule : dmairq_regs

// ===== hdl/dmairq_pkg.sv
package dmairq_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_MASKED_IRQ    = 12'h000;
    localparam logic [11:0] OFS_MASKED_TC     = 12'h004;
    localparam logic [11:0] OFS_TC_CLEAR      = 12'h008;
    localparam logic [11:0] OFS_MASKED_ERR    = 12'h00C;
    localparam logic [11:0] OFS_ERR_CLEAR     = 12'h010;
    localparam logic [11:0] OFS_RAW_TC        = 12'h014;
    localparam logic [11:0] OFS_RAW_ERR       = 12'h018;
    localparam logic [11:0] OFS_CHAN_ACTIVE   = 12'h01C;
    localparam logic [11:0] OFS_SW_BURST      = 12'h020;
    localparam logic [11:0] OFS_SW_SINGLE     = 12'h024;
    localparam logic [11:0] OFS_TC_MASK       = 12'h040;
    localparam logic [11:0] OFS_ERR_MASK      = 12'h044;
    localparam logic [11:0] OFS_CHAN_ENABLE   = 12'h048;
    // widths
    localparam int NUM_CHAN = 8;
    localparam int NUM_SRC  = 16;
    // reset values
    localparam logic [7:0]  RST_CHAN = 8'h00;
    localparam logic [15:0] RST_SRC  = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // events from the channel engines
    typedef struct packed {
        logic [7:0]  tc_set;       // terminal count reached, per channel
        logic [7:0]  err_set;      // transfer error, per channel
        logic [7:0]  chan_done;    // channel finished, per channel
        logic [15:0] burst_done;   // burst transaction done, per source
        logic [15:0] single_done;  // single transaction done, per source
    } dmairq_evt_t;

    // interrupt outputs
    typedef struct packed {
        logic combined;
        logic tc;
        logic err;
    } dmairq_irq_t;
endpackage : dmairq_pkg

// ===== hdl/dmairq_sticky.sv
`timescale 1ns/1ns
// sticky flag bank: set wins over clear, width set by W
module dmairq_sticky #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set_bits,   // hardware or software set
    input  wire logic [W-1:0] clr_bits,   // clear request
    output logic      [W-1:0] flags       // registered state
);
    logic [W-1:0] flags_next;             // next flag state

    // per bit: set has priority over clear
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                flags_next[g] = set_bits[g] | (flags[g] & ~clr_bits[g]);
            end
        end
    endgenerate

    // register the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags <= flags_next;
        end
    end
endmodule : dmairq_sticky

// ===== test/dmairq_periph.sv
`timescale 1ns/1ns
// far side: channel engines and peripherals that finish requests
module dmairq_periph
    import dmairq_pkg::*;
#(
    parameter int DLY = 4  // cycles a request stands before it completes
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    serve,     // finish pending requests
    input  wire dmairq_pkg::dmairq_evt_t chan_evt,  // channel events from bench
    input  wire logic [15:0]             burst_req_out,
    input  wire logic [15:0]             single_req_out,
    output dmairq_pkg::dmairq_evt_t      evt
);
    logic [7:0]  wait_reg;   // cycles the current request has stood
    logic [15:0] bdone_reg;  // burst completion pulse
    logic [15:0] sdone_reg;  // single completion pulse
    ////////////////////////////////////////////////////////////////
    // completion pulses once requests have stood DLY cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg  <= 8'h00;
            bdone_reg <= 16'h0000;
            sdone_reg <= 16'h0000;
        end else begin
            bdone_reg <= 16'h0000;
            sdone_reg <= 16'h0000;
            if (!serve || (burst_req_out | single_req_out) == 16'h0000)
                wait_reg <= 8'h00;
            else if (wait_reg == DLY[7:0]) begin
                wait_reg  <= 8'h00;
                bdone_reg <= burst_req_out;
                sdone_reg <= single_req_out;
            end else
                wait_reg <= wait_reg + 8'h01;
        end
    end
    // bench gives channel events, the model adds completions
    always_comb begin
        evt             = chan_evt;
        evt.burst_done  = bdone_reg;
        evt.single_done = sdone_reg;
    end
endmodule : dmairq_periph

// ===== test/dmairq_regs_sva.sv
`timescale 1ns/1ns
// port-level checks of the register block
module dmairq_regs_sva
    import dmairq_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire dmairq_pkg::dmairq_evt_t evt,
    input wire logic [15:0]             hw_burst_req,
    input wire logic [15:0]             hw_single_req,
    input wire logic [15:0]             burst_req_out,
    input wire logic [15:0]             single_req_out,
    input wire logic [7:0]              chan_enable_out,
    input wire dmairq_pkg::dmairq_irq_t irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    irq_combined_a: assert property (irq.combined == (irq.tc || irq.err))
        else $error("combined irq differs");
    hw_burst_a: assert property (1'b1 |=>
        ((burst_req_out & $past(hw_burst_req)) == $past(hw_burst_req)))
        else $error("hw burst lost");
    hw_single_a: assert property (1'b1 |=>
        ((single_req_out & $past(hw_single_req)) == $past(hw_single_req)))
        else $error("hw single lost");
    sw_burst_a: assert property (pready && pwrite && paddr == OFS_SW_BURST |-> ##2
        ((burst_req_out & $past(pwdata[15:0], 2)) == $past(pwdata[15:0], 2)))
        else $error("sw burst not raised");
    chan_done_a: assert property (|evt.chan_done |-> ##2
        ((chan_enable_out & $past(evt.chan_done, 2)) == 8'h00))
        else $error("channel stays enabled");
    clear_read_a: assert property (pready && !pwrite
        && (paddr == OFS_TC_CLEAR || paddr == OFS_ERR_CLEAR)
        |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("clear register read nonzero");
    upper_zero_a: assert property (pready && !pwrite && paddr < OFS_SW_BURST
        |-> prdata[31:8] == 24'h000000)
        else $error("upper status bits set");
    cover property (irq.combined);
    cover property (pslverr);
    cover property (|evt.burst_done);
endmodule : dmairq_regs_sva

bind dmairq_regs dmairq_regs_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .hw_burst_req(hw_burst_req), .hw_single_req(hw_single_req),
    .burst_req_out(burst_req_out), .single_req_out(single_req_out),
    .chan_enable_out(chan_enable_out), .irq(irq));

// ===== test/dmairq_regs_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module dmairq_regs_bench;
    import dmairq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serve, eq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] hw_burst_req, hw_single_req, burst_req_out, single_req_out;
    logic [7:0]  chan_enable_out;
    dmairq_evt_t evt, chan_evt;
    dmairq_irq_t irq;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    dmairq_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .hw_burst_req(hw_burst_req),
        .hw_single_req(hw_single_req), .burst_req_out(burst_req_out),
        .single_req_out(single_req_out), .chan_enable_out(chan_enable_out), .irq(irq));
    dmairq_periph u_far (.pclk(pclk), .presetn(presetn), .serve(serve), .chan_evt(chan_evt),
        .burst_req_out(burst_req_out), .single_req_out(single_req_out), .evt(evt));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; no local limit, only the bench timeout
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        eq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle so the next setup never reassigns psel in this step
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic pulse(input dmairq_evt_t v);
        chan_evt <= v;
        @(posedge pclk);
        chan_evt <= '0;
        @(posedge pclk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 0; a < 40; a += 4)
            rd(a[11:0], 32'h0);
        apb(1'b0, 12'h050, 32'h0);
        `CHK("slverr", 1'b1, eq);
        $display("test reset done");
    endtask : t_reset
    task automatic t_irq();
        apb(1'b1, OFS_TC_MASK, 32'h01);
        apb(1'b1, OFS_ERR_MASK, 32'h40);
        pulse('{tc_set: 8'h81, err_set: 8'h42, default: '0});
        rd(OFS_RAW_TC, 32'h81);
        rd(OFS_MASKED_TC, 32'h01);
        rd(OFS_RAW_ERR, 32'h42);
        rd(OFS_MASKED_ERR, 32'h40);
        rd(OFS_MASKED_IRQ, 32'h41);
        `CHK("irq", 3'b111, irq);
        apb(1'b1, OFS_TC_CLEAR, 32'h01);
        rd(OFS_RAW_TC, 32'h80);
        `CHK("irq", 3'b101, irq);
        apb(1'b1, OFS_ERR_CLEAR, 32'h42);
        rd(OFS_RAW_ERR, 32'h00);
        `CHK("irq", 3'b000, irq);
        $display("test irq done");
    endtask : t_irq
    task automatic t_enable();
        apb(1'b1, OFS_CHAN_ENABLE, 32'h0F);
        rd(OFS_CHAN_ACTIVE, 32'h0F);
        pulse('{chan_done: 8'h03, default: '0});
        rd(OFS_CHAN_ACTIVE, 32'h0C);
        `CHK("chan_enable_out", 8'h0C, chan_enable_out);
        $display("test enable done");
    endtask : t_enable
    task automatic t_sw();
        apb(1'b1, OFS_SW_BURST, 32'h0005);
        apb(1'b1, OFS_SW_BURST, 32'h0000);
        apb(1'b1, OFS_SW_SINGLE, 32'h8000);
        rd(OFS_SW_BURST, 32'h0005);
        rd(OFS_SW_SINGLE, 32'h8000);
        `CHK("burst_req_out", 16'h0005, burst_req_out);
        `CHK("single_req_out", 16'h8000, single_req_out);
        serve <= 1'b1;
        for (int n = 0; n < 40 && (burst_req_out | single_req_out) !== 16'h0; n++)
            @(posedge pclk);
        rd(OFS_SW_BURST, 32'h0);
        rd(OFS_SW_SINGLE, 32'h0);
        serve <= 1'b0;
        $display("test software request done");
    endtask : t_sw
    task automatic t_hw();
        hw_burst_req <= 16'h0100;  // reaches the engines whether or not a software request stands
        hw_single_req <= 16'h0002;
        repeat (2) @(posedge pclk);
        `CHK("burst_req_out", 16'h0100, burst_req_out);
        `CHK("single_req_out", 16'h0002, single_req_out);
        rd(OFS_SW_BURST, 32'h0100);
        rd(OFS_SW_SINGLE, 32'h0002);
        hw_burst_req <= 16'h0;
        hw_single_req <= 16'h0;
        $display("test hardware request done");
    endtask : t_hw
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, serve} = '0;
        {paddr, pwdata, hw_burst_req, hw_single_req} = '0;
        chan_evt = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_irq();
        t_enable();
        t_sw();
        t_hw();
        results();
    end
endmodule : dmairq_regs_bench
